// >>> core/backlight_i2c_slave_port.sv
// two-wire serial slave port with shutdown/active gating of a backlight driver
`default_nettype none
module backlight_i2c_slave_port import bl_pkg::*; (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic enable_io_supply_input_i,
  input wire logic pwm_i,
  input wire logic [7:0] fault_i,
  output logic active_o,
  output logic shutdown_o,
  output logic backlight_on_o,
  output logic bus_busy_o,
  output logic [7:0] brightness_o,
  output logic [1:0] brightness_source_select_o,
  output logic [5:0] led_enable_o
);
  // ==========================================
  // pin synchronisation
  logic [3:0] pins_s;
  logic [7:0] fault_s;
  logic scl_s;
  logic sda_s;
  logic en_s;
  logic pwm_s;

  pin_sync #(.W(4)) u_pin_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .d_i({pwm_i, enable_io_supply_input_i, sda_i, scl_i}),
    .q_o(pins_s)
  );

  pin_sync #(.W(8)) u_fault_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .d_i(fault_i),
    .q_o(fault_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign en_s = pins_s[2];
  assign pwm_s = pins_s[3];

  // ==========================================
  // line event detection
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // idle lines sit high, so the history resets high to avoid a false start
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce_i) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

  logic busy_q;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
    end else if (ce_i) begin
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det || !en_s) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // operating mode
  logic [7:0] brt_w;
  logic [7:0] ctrl_w;
  logic [5:0] led_en_w;
  logic [1:0] sel_w;
  logic bl_on_d;
  logic active_q;
  logic bl_on_q;

  assign sel_w = ctrl_w[CTRL_SEL_MSB:CTRL_SEL_LSB];
  assign bl_on_d = (sel_w != SEL_PWM_ONLY) ? ctrl_w[CTRL_ON_BIT] : pwm_s;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_q <= 1'b0;
      bl_on_q <= 1'b0;
    end else if (ce_i) begin
      active_q <= en_s && bl_on_d;
      bl_on_q <= en_s && bl_on_d;
    end
  end

  // ==========================================
  // serial state machine
  i2c_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] rdata_w;
  logic rw_q;
  logic ack_q;
  logic mack_q;
  logic quiet;
  logic byte_done;
  logic refuse;
  logic wr_stb;
  logic rd_stb;

  assign quiet = en_s && !start_det && !stop_det;
  assign byte_done = scl_fall && (cnt_q == BITS_PER_BYTE);
  assign refuse = active_q && is_cfg(ptr_q);
  assign wr_stb = quiet && (state_q == ST_WR) && byte_done && !refuse;
  assign rd_stb = quiet && scl_fall && (((state_q == ST_ADDR_ACK) && rw_q) ||
                  ((state_q == ST_RD_ACK) && mack_q));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (ce_i) begin
      if (!en_s || stop_det) begin
        state_q <= ST_IDLE;
        ack_q <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_REG, ST_WR: begin
            if (scl_rise && cnt_q != BITS_PER_BYTE) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_done) begin
              cnt_q <= 4'h0;
              if (state_q == ST_ADDR) begin
                if (sh_q[7:1] == SLAVE_ADDR) begin
                  state_q <= ST_ADDR_ACK;
                  ack_q <= 1'b1;
                  rw_q <= sh_q[0];
                end else begin
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_REG) begin
                ptr_q <= sh_q;
                state_q <= ST_REG_ACK;
                ack_q <= 1'b1;
              end else begin
                state_q <= ST_WR_ACK;
                ack_q <= !refuse;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              ack_q <= 1'b0;
              cnt_q <= 4'h0;
              if (rw_q) begin
                state_q <= ST_RD;
                tx_q <= rdata_w;
              end else begin
                state_q <= ST_REG;
              end
            end
          end
          ST_REG_ACK: begin
            if (scl_fall) begin
              ack_q <= 1'b0;
              state_q <= ST_WR;
            end
          end
          ST_WR_ACK: begin
            if (scl_fall) begin
              ack_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (cnt_q == TX_LAST) begin
                state_q <= ST_RD_ACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              mack_q <= !sda_s;
              if (!sda_s) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (mack_q) begin
                state_q <= ST_RD;
                tx_q <= rdata_w;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // register storage
  reg_bank u_reg_bank (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .clear_i(!en_s),
    .wr_i(wr_stb),
    .rd_i(rd_stb),
    .addr_i(ptr_q),
    .wdata_i(sh_q),
    .fault_set_i(fault_s),
    .rdata_o(rdata_w),
    .brt_o(brt_w),
    .ctrl_o(ctrl_w),
    .led_en_o(led_en_w)
  );

  // ==========================================
  // pin drive and outputs
  // hold sda low on ack clock
  // release sda in master ack slot
  assign sda_oe_o = (ack_q && (state_q == ST_ADDR_ACK || state_q == ST_REG_ACK ||
                    state_q == ST_WR_ACK)) || ((state_q == ST_RD) && !tx_q[7]);
  assign sda_o = 1'b0;
  assign active_o = active_q;
  assign shutdown_o = !active_q;
  assign backlight_on_o = bl_on_q;
  assign bus_busy_o = busy_q;
  assign brightness_o = brt_w;
  assign brightness_source_select_o = sel_w;
  assign led_enable_o = led_en_w;

  // ==========================================
  // assertions
  property p_shutdown;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && !en_s) |=> (state_q == ST_IDLE) && !active_q;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("not in shutdown with enable low");

  property p_bl_on;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && en_s && sel_w != SEL_PWM_ONLY) |=> (bl_on_q == $past(ctrl_w[CTRL_ON_BIT]));
  endproperty
  a_bl_on: assert property (p_bl_on)
    else $error("backlight does not follow on bit");

  property p_cfg_refuse;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && quiet && state_q == ST_WR && byte_done && refuse)
        |-> !wr_stb ##1 (state_q == ST_WR_ACK && !sda_oe_o);
  endproperty
  a_cfg_refuse: assert property (p_cfg_refuse)
    else $error("configuration write accepted while active");

  property p_abort;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && stop_det) |=> (state_q == ST_IDLE) && !sda_oe_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("transaction not aborted");

  property p_start;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && en_s && start_det) |=> (state_q == ST_ADDR) && (cnt_q == 4'h0) && busy_q;
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken as address phase");

  property p_busy;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && stop_det) |=> !busy_q;
  endproperty
  a_busy: assert property (p_busy)
    else $error("bus busy after stop");

  property p_byte_len;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && state_q == ST_ADDR_ACK && $past(state_q) == ST_ADDR && $rose(ack_q))
        |-> ($past(cnt_q) == BITS_PER_BYTE);
  endproperty
  a_byte_len: assert property (p_byte_len)
    else $error("ack after wrong bit count");

  property p_addr_miss;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && quiet && state_q == ST_ADDR && byte_done && sh_q[7:1] != SLAVE_ADDR)
        |=> (state_q == ST_IDLE) && !sda_oe_o;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address acknowledged");

  property p_ack_drive;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (state_q == ST_REG_ACK) |-> sda_oe_o;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("register address not acknowledged");

  property p_release;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (state_q == ST_RD_ACK || state_q == ST_IDLE) |-> !sda_oe_o;
  endproperty
  a_release: assert property (p_release)
    else $error("sda driven in master ack slot");

  property p_wr_incr;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && quiet && state_q == ST_WR_ACK && scl_fall)
        |=> (ptr_q == $past(ptr_q) + 8'h01) && (state_q == ST_WR);
  endproperty
  a_wr_incr: assert property (p_wr_incr)
    else $error("write pointer not incremented");

  property p_rd_incr;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && quiet && state_q == ST_RD_ACK && scl_rise && !sda_s)
        |=> (ptr_q == $past(ptr_q) + 8'h01);
  endproperty
  a_rd_incr: assert property (p_rd_incr)
    else $error("read pointer not incremented");

  c_write: cover property (@(posedge core_clk_i) disable iff (!resetn_i) wr_stb);
  c_read_burst: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    rd_stb && state_q == ST_RD_ACK);
  c_refused: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    state_q == ST_WR_ACK && !ack_q);
  c_restart: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    start_det && busy_q);
endmodule // backlight_i2c_slave_port
`default_nettype wire

// >>> core/bl_pkg.sv
// shared constants, types and helpers of the backlight serial slave port
`default_nettype none
package bl_pkg;
  // ==========================================
  // bus address and register map
  localparam logic [6:0] SLAVE_ADDR = 7'h2C;
  localparam logic [7:0] REG_BRT = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_DIRECT = 8'h04;
  localparam logic [7:0] REG_LED_EN = 8'h16;
  localparam logic [7:0] REG_CFG_LO = 8'h98;
  localparam logic [3:0] CFG_PAGE = 4'hA;
  // ==========================================
  // reset values
  localparam logic [7:0] BRT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] DIRECT_RST = 8'h00;
  localparam logic [5:0] LED_EN_RST = 6'h3F;
  localparam logic [7:0] CFG_RST = 8'h00;
  // ==========================================
  // field positions and counts
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_SEL_MSB = 2;
  localparam int CFG_DEPTH = 16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;
  localparam logic [1:0] SEL_PWM_ONLY = 2'h0;
  // ==========================================
  // serial state machine
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } i2c_state_t;

  // configuration space starts at the first eprom-style address
  function automatic logic is_cfg(input logic [7:0] a);
    return (a >= REG_CFG_LO);
  endfunction
endpackage
`default_nettype wire

// >>> core/pin_sync.sv
// two-flop synchroniser for inputs from outside the core clock domain
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // pin_sync
`default_nettype wire

// >>> core/reg_bank.sv
// register storage behind the serial slave port
`default_nettype none
module reg_bank import bl_pkg::*; (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] fault_set_i,
  output logic [7:0] rdata_o,
  output logic [7:0] brt_o,
  output logic [7:0] ctrl_o,
  output logic [5:0] led_en_o
);
  logic [7:0] brt_q;
  logic [7:0] ctrl_q;
  logic [7:0] status_q;
  logic [7:0] direct_q;
  logic [5:0] led_en_q;
  logic [7:0] cfg_mem [CFG_DEPTH];
  logic status_rd;

  // ==========================================
  // control registers, wiped in shutdown
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      brt_q <= BRT_RST;
      ctrl_q <= CTRL_RST;
      direct_q <= DIRECT_RST;
      led_en_q <= LED_EN_RST;
    end else if (ce_i) begin
      if (clear_i) begin
        brt_q <= BRT_RST;
        ctrl_q <= CTRL_RST;
        direct_q <= DIRECT_RST;
        led_en_q <= LED_EN_RST;
      end else if (wr_i) begin
        case (addr_i)
          REG_BRT: brt_q <= wdata_i;
          REG_CTRL: ctrl_q <= wdata_i;
          REG_DIRECT: direct_q <= wdata_i;
          REG_LED_EN: led_en_q <= wdata_i[5:0];
          default: ;
        endcase
      end
    end
  end

  // configuration words survive shutdown, like non-volatile trim
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfg_mem[i] <= CFG_RST;
      end
    end else if (ce_i && wr_i && addr_i[7:4] == CFG_PAGE) begin
      cfg_mem[addr_i[3:0]] <= wdata_i;
    end
  end

  // ==========================================
  // fault status
  assign status_rd = rd_i && (addr_i == REG_STATUS);

  // read clears faults
  // a fault arriving with the clearing read stays set
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_q <= STATUS_RST;
    end else if (ce_i) begin
      status_q <= ((status_rd || clear_i) ? STATUS_RST : status_q) | fault_set_i;
    end
  end

  always_comb begin
    rdata_o = 8'h00;
    if (addr_i[7:4] == CFG_PAGE) begin
      rdata_o = cfg_mem[addr_i[3:0]];
    end else begin
      case (addr_i)
        REG_BRT: rdata_o = brt_q;
        REG_CTRL: rdata_o = ctrl_q;
        REG_STATUS: rdata_o = status_q;
        REG_DIRECT: rdata_o = direct_q;
        REG_LED_EN: rdata_o = {2'h0, led_en_q};
        default: rdata_o = 8'h00;
      endcase
    end
  end

  assign brt_o = brt_q;
  assign ctrl_o = ctrl_q;
  assign led_en_o = led_en_q;

  property p_status_clear;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ce_i && status_rd && !clear_i) |=> (status_q == $past(fault_set_i));
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status not cleared by read");
endmodule // reg_bank
`default_nettype wire

// >>> tb/i2c_host_model.sv
// bus master model: drives the serial clock and pulls the data line low
`default_nettype none
module i2c_host_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock stands high between frames, data line released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // ==========================================
  // framing
  // master start edge
  task automatic start_c();
    #200 sda_low_o = 1'b0;
    scl_o = 1'b1;
    #200 sda_low_o = 1'b1;
    #200 scl_o = 1'b0;
  endtask
  task automatic stop_c();
    #100 sda_low_o = 1'b1;
    #100 scl_o = 1'b1;
    #200 sda_low_o = 1'b0;
    #200;
  endtask
  // data moves while clock low
  // low phase 275 ns, high 125 ns: a 400 ns bit, long enough for the
  // slave's three-clock answer delay
  task automatic bit_c(input logic b, output logic s);
    #100 sda_low_o = ~b;
    #175 scl_o = 1'b1;
    #62 s = sda_i;
    #63 scl_o = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(d[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      d[i] = s;
    end
    bit_c(~ack, s);
  endtask
  // deliberate data edge inside a clock high phase
  task automatic glitch_c();
    #100 sda_low_o = 1'b1;
    #175 scl_o = 1'b1;
    #50 sda_low_o = 1'b0;
    #75 scl_o = 1'b0;
  endtask
endmodule // i2c_host_model
`default_nettype wire

// >>> tb/backlight_i2c_slave_port_tb.sv
// self-checking bench of the backlight serial slave port
`default_nettype none
module backlight_i2c_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bl_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic en = 1'b0;
  logic pwm = 1'b0;
  logic [7:0] fault = 8'h00;
  logic scl, sda_low, sda_o, sda_oe_o, active_o, shutdown_o, backlight_on_o, bus_busy_o;
  logic [7:0] brightness_o;
  logic [1:0] sel_o;
  logic [5:0] led_en_o;
  wire sda_w = (sda_oe_o ? sda_o : 1'b1) & ~sda_low;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic a;
  logic [7:0] d0, d1;

  always #25 core_clk_i = ~core_clk_i;

  backlight_i2c_slave_port backlight_i2c_slave_port_i (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .enable_io_supply_input_i(en),
    .pwm_i(pwm), .fault_i(fault), .active_o(active_o), .shutdown_o(shutdown_o),
    .backlight_on_o(backlight_on_o), .bus_busy_o(bus_busy_o),
    .brightness_o(brightness_o), .brightness_source_select_o(sel_o),
    .led_enable_o(led_en_o));

  i2c_host_model i2c_host_model_i (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));

  // ==========================================
  // checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // whole run needs some 3400 clocks
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic settle();
    repeat (6) @(posedge core_clk_i);
  endtask

  // ==========================================
  // bus transfers
  task automatic wr(input logic [7:0] ra, input logic [7:0] w0, input logic [7:0] w1,
                    input logic two, output logic ack);
    logic a0, a1;
    i2c_host_model_i.start_c();
    i2c_host_model_i.wr_byte({SLAVE_ADDR, 1'b0}, a0);
    i2c_host_model_i.wr_byte(ra, a1);
    // with enable low the port is deaf, so neither byte may be acknowledged
    check({6'h00, a0, a1}, en ? 8'h03 : 8'h00);
    i2c_host_model_i.wr_byte(w0, ack);
    if (two) i2c_host_model_i.wr_byte(w1, ack);
    i2c_host_model_i.stop_c();
    settle();
  endtask

  task automatic rd(input logic [7:0] ra, output logic [7:0] r0, output logic [7:0] r1);
    logic a0, a1, a2;
    i2c_host_model_i.start_c();
    i2c_host_model_i.wr_byte({SLAVE_ADDR, 1'b0}, a0);
    i2c_host_model_i.wr_byte(ra, a1);
    i2c_host_model_i.start_c();
    i2c_host_model_i.wr_byte({SLAVE_ADDR, 1'b1}, a2);
    check({5'h00, a0, a1, a2}, 8'h07);
    i2c_host_model_i.rd_byte(1'b1, r0);
    i2c_host_model_i.rd_byte(1'b0, r1);
    i2c_host_model_i.stop_c();
    settle();
  endtask

  // ==========================================
  // scenarios
  task automatic t_write_inc();
    wr(REG_BRT, 8'hA5, 8'h03, 1'b1, a);
    check(a, 1'b1);
    check(brightness_o, 8'hA5);
    check(sel_o, 2'h1);
    check({backlight_on_o, active_o, shutdown_o}, 3'b110);
    rd(REG_BRT, d0, d1);
    check(d0, 8'hA5);
    check(d1, 8'h03);
  endtask

  task automatic t_cfg_lock();
    wr(8'hA0, 8'h55, 8'h00, 1'b0, a);
    check(a, 1'b0);
    wr(REG_CTRL, 8'h00, 8'h00, 1'b0, a);
    check(active_o, 1'b0);
    wr(8'hA0, 8'h55, 8'h00, 1'b0, a);
    check(a, 1'b1);
    rd(8'hA0, d0, d1);
    check(d0, 8'h55);
    check(d1, CFG_RST);
  endtask

  task automatic t_pwm();
    @(posedge core_clk_i) pwm <= 1'b1;
    settle();
    check({backlight_on_o, active_o}, 2'b11);
    @(posedge core_clk_i) pwm <= 1'b0;
    settle();
    check(backlight_on_o, 1'b0);
  endtask

  task automatic t_status();
    @(posedge core_clk_i) fault <= 8'h04;
    repeat (3) @(posedge core_clk_i);
    fault <= 8'h00;
    settle();
    rd(REG_STATUS, d0, d1);
    check(d0, 8'h04);
    check(d1, 8'h00);
    rd(REG_STATUS, d0, d1);
    check(d0, 8'h00);
  endtask

  task automatic t_bad_addr();
    i2c_host_model_i.start_c();
    i2c_host_model_i.wr_byte({7'h2D, 1'b0}, a);
    check(a, 1'b0);
    i2c_host_model_i.wr_byte(REG_LED_EN, a);
    check(a, 1'b0);
    i2c_host_model_i.stop_c();
    settle();
  endtask

  task automatic t_abort();
    i2c_host_model_i.start_c();
    check(bus_busy_o, 1'b1);
    i2c_host_model_i.wr_byte({SLAVE_ADDR, 1'b0}, a);
    check(a, 1'b1);
    i2c_host_model_i.glitch_c();
    i2c_host_model_i.wr_byte({SLAVE_ADDR, 1'b0}, a);
    check(a, 1'b0);
    i2c_host_model_i.wr_byte(REG_BRT, a);
    check(a, 1'b0);
    i2c_host_model_i.stop_c();
    settle();
    check(bus_busy_o, 1'b0);
  endtask

  task automatic t_shutdown();
    @(posedge core_clk_i) en <= 1'b0;
    settle();
    check({shutdown_o, active_o}, 2'b10);
    check(brightness_o, BRT_RST);
    check(led_en_o, LED_EN_RST);
    wr(REG_BRT, 8'h11, 8'h00, 1'b0, a);
    check(brightness_o, BRT_RST);
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    en <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    check(led_en_o, LED_EN_RST);
    t_write_inc();
    t_cfg_lock();
    t_pwm();
    t_status();
    t_bad_addr();
    t_abort();
    t_shutdown();
    stop_test();
  end
endmodule // backlight_i2c_slave_port_tb
`default_nettype wire
